// ### design/rfh_pkg.sv
// Constants and carrier types for the RTC flag and hour-mode logic
package rfh_pkg;
  // ---------------------------------------------------------------
  // Register offsets on the multiplexed bus
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_CONTROL_OFF = 8'h0B;
  localparam logic [7:0] INTERRUPT_FLAGS_OFF = 8'h0C;
  localparam logic [7:0] RAM_VALID_STATUS_OFF = 8'h0D;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SET_MODE_BIT = 7;
  localparam int PIE_BIT = 6;
  localparam int AIE_BIT = 5;
  localparam int UIE_BIT = 4;
  localparam int DATA_MODE_BIT = 2;
  localparam int HOUR_24_BIT = 1;
  localparam int DSE_BIT = 0;
  localparam int SUMMARY_BIT = 7;
  localparam int PERIODIC_BIT = 6;
  localparam int ALARM_BIT = 5;
  localparam int UPDATE_BIT = 4;
  localparam int VRT_BIT = 7;
  localparam int PM_BIT = 7;
  // ---------------------------------------------------------------
  // Daylight-saving calendar points (binary values)
  // ---------------------------------------------------------------
  localparam logic [7:0] APRIL_MONTH = 8'h04;
  localparam logic [7:0] OCTOBER_MONTH = 8'h0A;
  localparam logic [7:0] SUNDAY_DOW = 8'h01;
  localparam logic [7:0] APRIL_LAST_WEEK = 8'h18;
  localparam logic [7:0] OCTOBER_LAST_WEEK = 8'h19;
  localparam logic [7:0] DST_HOUR = 8'h01;
  localparam logic [7:0] DST_MIN_SEC = 8'h3B;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Current time from the counters, in the active data mode
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rfh_time_type;

  // State reset by the reset pin (irq_b loads 1, all else clears)
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ds_q;
    logic rd_q;
    logic wr_q;
    logic [2:0] shown;
    logic periodic_flag;
    logic alarm_flag;
    logic update_ended_flag;
    logic periodic_int_enable;
    logic alarm_int_enable;
    logic update_end_int_enable;
    logic fall_done;
    logic [7:0] ad_out;
    logic ad_oe;
    logic irq_b;
    logic dst_fwd;
    logic dst_back;
  } rfh_state_type;

  // State that the reset pin leaves alone
  typedef struct packed {
    logic set_mode;
    logic data_mode;
    logic hour_24;
    logic daylight_saving_enable;
    logic valid_ram_time;
  } rfh_keep_type;
endpackage : rfh_pkg

// ### design/rfh_core.sv
// RTC interrupt flags, hour format, daylight saving and RAM-valid status
`timescale 1ns/1ps
`default_nettype none
module rfh_core
  import rfh_pkg::*;
(
  input wire logic sys_clk_i,         // 50 MHz clock
  input wire logic rst_b_i,           // Reset pin, active low
  input wire logic address_strobe_i,  // Address phase, high
  input wire logic data_strobe_i,     // Data phase, high
  input wire logic rw_i,              // 1 read, 0 write
  input wire logic ce_b_i,            // Chip enable, low
  input wire logic [7:0] ad_i,        // Bus input
  output logic [7:0] ad_o,            // Bus output
  output logic ad_oe_o,               // Bus drive enable
  output logic irq_b_o,               // Interrupt request, low
  input wire logic power_sense_in_i,  // Power sense pin
  input wire logic periodic_tick_i,   // Selected tap edge
  input wire logic alarm_match_i,     // Time equals alarm
  input wire logic update_end_i,      // Update cycle ended
  input wire logic update_start_i,    // Update cycle starts
  input wire rfh_time_type time_i,    // Current time
  output logic hour_24_mode_o,        // 24-hour format
  output logic data_mode_o,           // 1 binary, 0 BCD
  output logic set_mode_o,            // Updates inhibited
  output logic dst_forward_o,         // Load 3:00:00 at update
  output logic dst_back_o             // Load 1:00:00 at update
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic bin);
    if (bin)
      to_bin = v;
    else
      to_bin = 8'((v[7:4] * 4'hA) + v[3:0]);
  endfunction : to_bin

  rfh_state_type st_reg, st_next;
  rfh_keep_type kp_reg, kp_next;
  logic rd_end, wr_end, rd_flags_end, rd_status_end, wr_mode_end;
  logic at_015959, apr_day, oct_day, summary_interrupt_flag_next;
  logic [7:0] hour_bin, flags_rd, status_rd, mode_rd;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_end = st_reg.ds_q && !data_strobe_i && st_reg.rd_q;
    wr_end = st_reg.ds_q && !data_strobe_i && st_reg.wr_q;
    rd_flags_end = rd_end && st_reg.addr == INTERRUPT_FLAGS_OFF;
    rd_status_end = rd_end && st_reg.addr == RAM_VALID_STATUS_OFF;
    wr_mode_end = wr_end && st_reg.addr == MODE_CONTROL_OFF;
    hour_bin = to_bin({1'b0, time_i.hours[6:0]}, kp_reg.data_mode);
    at_015959 = hour_bin == DST_HOUR
      && (kp_reg.hour_24 || !time_i.hours[PM_BIT])
      && to_bin(time_i.minutes, kp_reg.data_mode) == DST_MIN_SEC
      && to_bin(time_i.seconds, kp_reg.data_mode) == DST_MIN_SEC;
    apr_day = to_bin(time_i.month, kp_reg.data_mode) == APRIL_MONTH
      && to_bin(time_i.dow, kp_reg.data_mode) == SUNDAY_DOW
      && to_bin(time_i.date, kp_reg.data_mode) >= APRIL_LAST_WEEK;
    oct_day = to_bin(time_i.month, kp_reg.data_mode) == OCTOBER_MONTH
      && to_bin(time_i.dow, kp_reg.data_mode) == SUNDAY_DOW
      && to_bin(time_i.date, kp_reg.data_mode) >= OCTOBER_LAST_WEEK;
    summary_interrupt_flag_next = (st_reg.periodic_flag && st_reg.periodic_int_enable)
      || (st_reg.alarm_flag && st_reg.alarm_int_enable)
      || (st_reg.update_ended_flag && st_reg.update_end_int_enable);
    flags_rd = ZERO_BYTE;
    flags_rd[SUMMARY_BIT] = summary_interrupt_flag_next;
    flags_rd[PERIODIC_BIT] = st_reg.periodic_flag;
    flags_rd[ALARM_BIT] = st_reg.alarm_flag;
    flags_rd[UPDATE_BIT] = st_reg.update_ended_flag;
    status_rd = ZERO_BYTE;
    status_rd[VRT_BIT] = kp_reg.valid_ram_time;
    mode_rd = ZERO_BYTE;
    mode_rd[SET_MODE_BIT] = kp_reg.set_mode;
    mode_rd[PIE_BIT] = st_reg.periodic_int_enable;
    mode_rd[AIE_BIT] = st_reg.alarm_int_enable;
    mode_rd[UIE_BIT] = st_reg.update_end_int_enable;
    mode_rd[DATA_MODE_BIT] = kp_reg.data_mode;
    mode_rd[HOUR_24_BIT] = kp_reg.hour_24;
    mode_rd[DSE_BIT] = kp_reg.daylight_saving_enable;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    kp_next = kp_reg;
    st_next.ds_q = data_strobe_i;
    if (address_strobe_i)
      st_next.addr = ad_i;
    if (data_strobe_i)
    begin
      st_next.rd_q = rw_i && !ce_b_i;
      st_next.wr_q = !rw_i && !ce_b_i;
      st_next.wdata = ad_i;
    end
    // Read data and drive enable
    st_next.ad_oe = 1'b0;
    st_next.ad_out = ZERO_BYTE;
    if (data_strobe_i && rw_i && !ce_b_i)
    begin
      st_next.ad_oe = 1'b1;
      unique case (st_reg.addr)
        MODE_CONTROL_OFF: st_next.ad_out = mode_rd;
        INTERRUPT_FLAGS_OFF: st_next.ad_out = flags_rd;
        RAM_VALID_STATUS_OFF: st_next.ad_out = status_rd;
        default: st_next.ad_oe = 1'b0;
      endcase
      if (st_reg.addr == INTERRUPT_FLAGS_OFF)
        st_next.shown = flags_rd[PERIODIC_BIT:UPDATE_BIT];
    end
    if (rd_flags_end)
    begin
      st_next.periodic_flag = st_reg.periodic_flag && !st_reg.shown[2];
      st_next.alarm_flag = st_reg.alarm_flag && !st_reg.shown[1];
      st_next.update_ended_flag =
        st_reg.update_ended_flag && !st_reg.shown[0];
      st_next.shown = 3'h0;
    end
    if (periodic_tick_i)
      st_next.periodic_flag = 1'b1;
    if (alarm_match_i)
      st_next.alarm_flag = 1'b1;
    if (update_end_i)
      st_next.update_ended_flag = 1'b1;
    if (wr_mode_end)
    begin
      kp_next.set_mode = st_reg.wdata[SET_MODE_BIT];
      st_next.periodic_int_enable = st_reg.wdata[PIE_BIT];
      st_next.alarm_int_enable = st_reg.wdata[AIE_BIT];
      st_next.update_end_int_enable = st_reg.wdata[UIE_BIT];
      kp_next.data_mode = st_reg.wdata[DATA_MODE_BIT];
      kp_next.hour_24 = st_reg.wdata[HOUR_24_BIT];
      kp_next.daylight_saving_enable = st_reg.wdata[DSE_BIT];
      if (st_reg.wdata[SET_MODE_BIT])
        st_next.update_end_int_enable = 1'b0;
    end
    st_next.irq_b = !((st_next.periodic_flag
                       && st_next.periodic_int_enable)
      || (st_next.alarm_flag && st_next.alarm_int_enable)
      || (st_next.update_ended_flag && st_next.update_end_int_enable));
    st_next.dst_fwd = update_start_i && !kp_reg.set_mode
      && kp_reg.daylight_saving_enable && apr_day && at_015959;
    st_next.dst_back = update_start_i && !kp_reg.set_mode
      && kp_reg.daylight_saving_enable && oct_day && at_015959
      && !st_reg.fall_done;
    if (st_next.dst_back)
      st_next.fall_done = 1'b1;
    else if (!oct_day)
      st_next.fall_done = 1'b0;
    if (rd_status_end)
      kp_next.valid_ram_time = 1'b1;
    if (!power_sense_in_i)
      kp_next.valid_ram_time = 1'b0;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '0;
      st_reg.irq_b <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  always_ff @(posedge sys_clk_i)
  begin
    kp_reg <= kp_next;
  end

  assign ad_o = st_reg.ad_out;
  assign ad_oe_o = st_reg.ad_oe;
  assign irq_b_o = st_reg.irq_b;
  assign hour_24_mode_o = kp_reg.hour_24;
  assign data_mode_o = kp_reg.data_mode;
  assign set_mode_o = kp_reg.set_mode;
  assign dst_forward_o = st_reg.dst_fwd;
  assign dst_back_o = st_reg.dst_back;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence flags_read_s;
    rd_flags_end && st_reg.shown[2] && !periodic_tick_i;
  endsequence
  sequence mode_set_write_s;
    wr_mode_end && st_reg.wdata[SET_MODE_BIT];
  endsequence

  hour_format_sw_a: assert property ($changed(kp_reg.hour_24)
    |-> $past(wr_mode_end)) else $error("hour format changed alone");
  spring_skip_a: assert property (dst_forward_o
    |-> $past(kp_reg.daylight_saving_enable && at_015959))
    else $error("spring skip without cause");
  fall_once_a: assert property (dst_back_o
    |=> st_reg.fall_done && !dst_back_o)
    else $error("fall back repeated");
  dse_keep_a: assert property ($changed(kp_reg.daylight_saving_enable)
    |-> $past(wr_mode_end)) else $error("enable changed alone");
  irq_pin_a: assert property (irq_b_o == !(
      (st_reg.periodic_flag && st_reg.periodic_int_enable)
      || (st_reg.alarm_flag && st_reg.alarm_int_enable)
      || (st_reg.update_ended_flag && st_reg.update_end_int_enable)))
    else $error("interrupt pin mismatch");
  flags_clear_a: assert property (flags_read_s |=> !st_reg.periodic_flag)
    else $error("flag not cleared");
  periodic_set_a: assert property (periodic_tick_i
    |=> st_reg.periodic_flag) else $error("periodic event lost");
  alarm_set_a: assert property (alarm_match_i
    |=> st_reg.alarm_flag) else $error("alarm event lost");
  update_set_a: assert property (update_end_i
    |=> st_reg.update_ended_flag) else $error("update event lost");
  flag_low_zero_a: assert property (ad_oe_o
    && $past(st_reg.addr) == INTERRUPT_FLAGS_OFF |-> ad_o[3:0] == 4'h0)
    else $error("flag low bits nonzero");
  vrt_power_a: assert property (!power_sense_in_i
    |=> !kp_reg.valid_ram_time) else $error("valid bit kept");
  vrt_set_a: assert property ($rose(kp_reg.valid_ram_time)
    |-> $past(rd_status_end)) else $error("valid bit set alone");
  uie_clear_a: assert property (mode_set_write_s
    |=> !st_reg.update_end_int_enable) else $error("update enable kept");
endmodule : rfh_core
`default_nettype wire

// ### bench/rfh_host.sv
// Host model: multiplexed address/data bus master
`timescale 1ns/1ps
`default_nettype none
module rfh_host
(
  input wire logic clk_i,       // Bus clock
  input wire logic [7:0] ad_i,  // Device read data
  input wire logic ad_oe_i,     // Device drive enable
  output logic as_o,            // Address strobe
  output logic ds_o,            // Data strobe
  output logic rw_o,            // 1 read, 0 write
  output logic ce_b_o,          // Chip enable, low
  output logic [7:0] ad_o       // Bus to device
);
  initial
  begin
    as_o = 1'b0;
    ds_o = 1'b0;
    rw_o = 1'b1;
    ce_b_o = 1'b1;
    ad_o = 8'hA5;
  end

  task automatic xfer(input logic [7:0] a, input logic rd,
    input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    as_o <= 1'b1;
    ce_b_o <= 1'b0;
    ad_o <= a;
    @(posedge clk_i);
    as_o <= 1'b0;
    ad_o <= ~a;
    @(posedge clk_i);
    ds_o <= 1'b1;
    rw_o <= rd;
    ad_o <= rd ? ~a : d;
    @(posedge clk_i);
    ds_o <= 1'b0;
    #1;
    q = ad_i;
    oe = ad_oe_i;
    @(posedge clk_i);
    ce_b_o <= 1'b1;
    rw_o <= 1'b1;
    ad_o <= ~ad_o;
  endtask : xfer
endmodule : rfh_host
`default_nettype wire

// ### bench/rtc_flags_and_hour_modes_tb.sv
// Self-checking bench for the RTC flag and hour-mode logic
`timescale 1ns/1ps
`default_nettype none
module rtc_flags_and_hour_modes_tb;
  import rfh_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b, as, ds, rw, ce_b, oe, irq_b, ps, h24, fwd, back;
  logic dm, sm, oe_q;
  logic [7:0] ad_h, ad_d, q, d, m;
  logic [3:0] ev;
  logic [2:0] en, f;
  rfh_time_type tm;
  int failures = 0;
  int cmp_count = 0;
  int fwd_n = 0;
  int back_n = 0;
  int seed = 66;

  always #10 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
  begin
    fwd_n += fwd;
    back_n += back;
  end

  rfh_core dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .address_strobe_i(as), .data_strobe_i(ds), .rw_i(rw), .ce_b_i(ce_b),
    .ad_i(ad_h), .ad_o(ad_d), .ad_oe_o(oe), .irq_b_o(irq_b),
    .power_sense_in_i(ps), .periodic_tick_i(ev[0]),
    .alarm_match_i(ev[1]), .update_end_i(ev[2]), .update_start_i(ev[3]),
    .time_i(tm), .hour_24_mode_o(h24), .data_mode_o(dm), .set_mode_o(sm),
    .dst_forward_o(fwd), .dst_back_o(back));
  rfh_host host_u (.clk_i(sys_clk), .ad_i(ad_d), .ad_oe_i(oe), .as_o(as),
    .ds_o(ds), .rw_o(rw), .ce_b_o(ce_b), .ad_o(ad_h));

  task automatic check(input string n, input logic [7:0] s,
    input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic o;
    host_u.xfer(a, 1'b0, v, q, o);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host_u.xfer(a, 1'b1, 8'h00, v, oe_q);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : pulse

  function automatic logic [7:0] exp_flags(input logic [2:0] fl,
    input logic [2:0] ena);
    return {|(fl & ena), fl, 4'h0};
  endfunction : exp_flags

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #1_000_000;
    failures++;
    end_of_test();
  end

  initial
  begin
    rst_b = 1'b0;
    ps = 1'b0;
    ev = 4'h0;
    tm = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    ps <= 1'b1;
    #1;
    check("irq_reset", {7'h00, irq_b}, 8'h01);
    wr(MODE_CONTROL_OFF, 8'h96);
    rd(MODE_CONTROL_OFF, d);
    check("set_clears_uie", d, 8'h86);
    check("read_oe", {7'h00, oe_q}, 8'h01);
    check("set_dm", {6'h00, sm, dm}, 8'h03);
    for (int i = 0; i < 12; i++)
    begin
      m = 8'($random(seed));
      en = m[2:0];
      f = m[5:3];
      wr(MODE_CONTROL_OFF, {1'b0, en, 4'h6});
      rd(MODE_CONTROL_OFF, d);
      check("mode", d, {1'b0, en, 4'h6});
      check("hour24", {7'h00, h24}, 8'h01);
      for (int k = 0; k < 3; k++)
        if (f[2 - k])
          pulse(k);
      check("irq_pin", {7'h00, irq_b}, {7'h00, ~|(f & en)});
      wr(INTERRUPT_FLAGS_OFF, 8'h0F);
      rd(INTERRUPT_FLAGS_OFF, d);
      check("flags", d, exp_flags(f, en));
      rd(INTERRUPT_FLAGS_OFF, d);
      check("flags_clear", d, 8'h00);
    end
    wr(MODE_CONTROL_OFF, 8'h06);
    fork
      rd(INTERRUPT_FLAGS_OFF, d);
      begin
        repeat (4) @(posedge sys_clk);
        ev[2] <= 1'b1;
        @(posedge sys_clk);
        ev[2] <= 1'b0;
      end
    join
    check("read_before_event", d, 8'h00);
    rd(INTERRUPT_FLAGS_OFF, d);
    check("event_in_read", d, 8'h10);
    rd(8'h3F, d);
    check("unmapped_oe", {7'h00, oe_q}, 8'h00);
    wr(MODE_CONTROL_OFF, 8'h05);
    tm <= {APRIL_MONTH, APRIL_LAST_WEEK, SUNDAY_DOW, DST_HOUR,
      DST_MIN_SEC, DST_MIN_SEC};
    pulse(3);
    check("spring", fwd_n[7:0], 8'h01);
    tm.month = OCTOBER_MONTH;
    tm.date = OCTOBER_LAST_WEEK;
    pulse(3);
    pulse(3);
    check("fall_once", back_n[7:0], 8'h01);
    wr(MODE_CONTROL_OFF, 8'h04);
    tm.month <= APRIL_MONTH;
    tm.date <= APRIL_LAST_WEEK;
    pulse(3);
    check("dse_off", fwd_n[7:0], 8'h01);
    ps <= 1'b0;
    rd(RAM_VALID_STATUS_OFF, d);
    check("vrt_low", d, 8'h00);
    ps <= 1'b1;
    rd(RAM_VALID_STATUS_OFF, d);
    check("vrt_before_set", d, 8'h00);
    wr(RAM_VALID_STATUS_OFF, 8'h7F);
    rd(RAM_VALID_STATUS_OFF, d);
    check("vrt_set", d, 8'h80);
    wr(MODE_CONTROL_OFF, 8'h75);
    pulse(0);
    check("irq_before_reset", {7'h00, irq_b}, 8'h00);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    check("irq_after_reset", {7'h00, irq_b}, 8'h01);
    rd(INTERRUPT_FLAGS_OFF, d);
    check("reset_clears", d, 8'h00);
    rd(RAM_VALID_STATUS_OFF, d);
    check("vrt_keep", d, 8'h80);
    rd(MODE_CONTROL_OFF, d);
    check("mode_keep", d, 8'h05);
    check("modes_keep", {6'h00, sm, dm}, 8'h01);
    end_of_test();
  end
endmodule : rtc_flags_and_hour_modes_tb
`default_nettype wire
